// File: hdl/srx_serial_receiver.sv
// receive path of the addressable serial port with apb registers
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module srx_serial_receiver
  import srx_pkg::*;
(
  // clock and reset
  input  wire logic         mclk_in,
  input  wire logic         reset_in,
  // apb slave
  input  wire srx_apb_req_s apb_req_in,
  output var  srx_apb_rsp_s apb_rsp_out,
  // serial link pins
  input  wire logic         serial_data_pin_in,
  input  wire logic         serial_clk_in,
  output logic              serial_clk_out,
  output logic              serial_clk_oe_out,
  // receive interrupt request
  output logic              rx_irq_out
);

  // all state of the block; every flop sits in this one struct so that
  // reset and next-state handling cannot drift apart from each other
  typedef struct packed {
    srx_apb_rsp_s   rsp;
    logic           pop_pend;
    logic [7:0]     irq_control;
    logic [7:0]     periph_enables;
    logic [7:0]     tx_status;
    logic [7:0]     baud;
    logic [4:0]     rs_ctl;           // bits 7..3 of receive status
    logic           overrun;
    srx_word_s [1:0] fifo;
    logic           head;
    logic [1:0]     count;
    srx_state_e     fsm;
    logic [8:0]     shreg;
    logic [3:0]     bitcnt;
    logic [7:0]     brg;
    logic [5:0]     os;
    logic           d_s1;
    logic           d_s2;
    logic           d_prev;
    logic           c_s1;
    logic           c_s2;
    logic           c_prev;
    logic           clk_out;
    logic           clk_oe;
    logic           irq;
  } srx_regs_s;

  srx_regs_s r;
  srx_regs_s next_r;

  // composes the read value of a register index; reading has no side
  // effect here, the fifo pops only at the edge that completes the access
  function automatic logic [7:0] read_mux(input srx_regs_s s,
                                          input logic [7:0] idx);
    srx_word_s h;
    // an empty fifo shows a zero head so stale status bits never leak
    h = '0;
    if (s.count != 2'd0) begin
      h = s.fifo[s.head];
    end
    unique case (idx)
      IDX_IRQ_CONTROL:    read_mux = s.irq_control;
      IDX_PERIPH_FLAGS:   read_mux = 8'(s.count != 2'd0) << PF_RECEIVE_FLAG;
      IDX_RX_STATUS:      read_mux = {s.rs_ctl, h.framing_error,
                                      s.overrun, h.word[8]};
      IDX_RX_DATA:        read_mux = h.word[7:0];
      IDX_PERIPH_ENABLES: read_mux = s.periph_enables;
      IDX_TX_STATUS:      read_mux = s.tx_status
                                     | (8'h01 << TS_SHIFT_EMPTY);
      IDX_BAUD_DIVISOR:   read_mux = s.baud;
      default:            read_mux = 8'h00;
    endcase
  endfunction

  // checks that an address is a word of the register map
  // misaligned or unknown addresses answer with an error and no effect
  function automatic logic mapped(input logic [APB_ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    mapped = (a[1:0] == 2'b00) &&
             (i == IDX_IRQ_CONTROL || i == IDX_PERIPH_FLAGS ||
              i == IDX_RX_STATUS || i == IDX_RX_DATA ||
              i == IDX_PERIPH_ENABLES || i == IDX_TX_STATUS ||
              i == IDX_BAUD_DIVISOR);
  endfunction

  // next-state logic
  // every field starts from its current value; only what changes is set
  always_comb begin
    logic        setup;
    logic        done;
    logic        wr;
    logic [7:0]  idx;
    logic [7:0]  wd;
    logic        serial_port_enable;
    logic        sync;
    logic        master;
    logic        active;
    logic        tick;
    logic        fall;
    logic        sample;
    logic [5:0]  os_top;
    logic [3:0]  nbits;
    logic        finish;
    logic        ferr;
    logic        push;
    logic        pop;
    srx_word_s   nw;
    next_r = r;
    setup  = 1'b0;
    done   = 1'b0;
    wr     = 1'b0;
    idx    = 8'h00;
    wd     = 8'h00;
    serial_port_enable   = 1'b0;
    sync   = 1'b0;
    master = 1'b0;
    active = 1'b0;
    tick   = 1'b0;
    fall   = 1'b0;
    sample = 1'b0;
    os_top = 6'd0;
    nbits  = 4'd0;
    finish = 1'b0;
    ferr   = 1'b0;
    push   = 1'b0;
    pop    = 1'b0;
    nw     = '0;

    // pin synchronisers; both pins come from outside the clock domain, so
    // only the second flop feeds logic and the third keeps the previous
    // synced level for edge finding; the data chain resets high, the idle
    // level of the line, so no false start edge follows reset
    next_r.d_s1   = serial_data_pin_in;
    next_r.d_s2   = r.d_s1;
    next_r.d_prev = r.d_s2;
    next_r.c_s1   = serial_clk_in;
    next_r.c_s2   = r.c_s1;
    next_r.c_prev = r.c_s2;

    // apb: answer one cycle after setup, effects at the completing edge
    // the pop is decided at setup from the same head word that prdata
    // carries, so the data returned and the word removed always agree
    idx   = apb_req_in.paddr[9:2];
    wd    = apb_req_in.pwdata[7:0];
    setup = apb_req_in.psel && !apb_req_in.penable;
    done  = apb_req_in.psel && apb_req_in.penable && r.rsp.pready;
    next_r.rsp.pready = setup;
    if (setup) begin
      next_r.rsp.pslverr = !mapped(apb_req_in.paddr);
      next_r.rsp.prdata  = (apb_req_in.pwrite || !mapped(apb_req_in.paddr))
                           ? 32'h0 : {24'h0, read_mux(r, idx)};
      next_r.pop_pend    = !apb_req_in.pwrite && mapped(apb_req_in.paddr)
                           && idx == IDX_RX_DATA && r.count != 2'd0;
    end
    wr  = done && apb_req_in.pwrite && !r.rsp.pslverr;
    pop = done && r.pop_pend;
    if (done) begin
      next_r.pop_pend = 1'b0;
    end

    // register writes; flag register and data are read only
    // writes there land in the default arm and change nothing
    if (wr) begin
      unique case (idx)
        IDX_IRQ_CONTROL:    next_r.irq_control = wd;
        IDX_RX_STATUS:      next_r.rs_ctl = wd[7:3];
        IDX_PERIPH_ENABLES: next_r.periph_enables = wd & PE_WMASK;
        IDX_TX_STATUS:      next_r.tx_status = wd & TX_STATUS_WMASK;
        IDX_BAUD_DIVISOR:   next_r.baud = wd;
        default:            next_r.baud = r.baud;
      endcase
    end

    // overrun clears only with continuous enable low
    // this is the only way out, so software can always recover reception
    if (!next_r.rs_ctl[RS_CONTINUOUS_RECEIVE-3]) begin
      next_r.overrun = 1'b0;
    end

    // mode decode; single enable only counts in clocked mode, async
    // reception needs continuous enable
    serial_port_enable   = r.rs_ctl[RS_SERIAL_PORT_ENABLE-3];
    sync   = r.tx_status[TS_CLOCKED_MODE_SELECT];
    master = r.tx_status[TS_CLOCK_SOURCE_MASTER];
    active = serial_port_enable && (r.rs_ctl[RS_CONTINUOUS_RECEIVE-3] ||
             (sync && r.rs_ctl[RS_SINGLE_RECEIVE-3]));
    nbits  = r.rs_ctl[RS_NINTH_BIT_ENABLE-3] ? BITS_WIDE
                                             : BITS_NARROW;
    os_top = r.tx_status[TS_HIGH_SPEED_BAUD] ? OVERSAMPLE_HI
                                             : OVERSAMPLE_LO;

    // baud tick every divisor plus one cycles
    // a new divisor takes effect at the next reload of the down counter
    tick = (r.brg == 8'h00);
    next_r.brg = tick ? r.baud : r.brg - 8'd1;

    // shift clock: master toggles on ticks, slave watches the pin; the
    // master clock only runs while reception is enabled and parks low
    // otherwise so the far side sees no stray rising edge
    if (sync && master && active && r.fsm == SRX_DATA) begin
      if (tick) begin
        next_r.clk_out = !r.clk_out;
        fall = r.clk_out;
      end
    end else begin
      next_r.clk_out = 1'b0;
      fall = sync && !master && r.c_prev && !r.c_s2;
    end
    next_r.clk_oe = serial_port_enable && sync && master;

    // receive sequencer
    // async: start, data bits, stop; clocked: data bits only, no framing
    unique case (r.fsm)
      SRX_IDLE: begin
        next_r.bitcnt = 4'd0;
        next_r.os     = 6'd0;
        if (active && sync) begin
          next_r.fsm = SRX_DATA;
        end else if (active && r.d_prev && !r.d_s2) begin
          next_r.fsm = SRX_START;
        end
      end
      SRX_START: begin
        // check the start bit at its middle
        // a glitch shorter than half a bit falls back to idle
        if (tick) begin
          next_r.os = r.os + 6'd1;
          if (r.os == (os_top >> 1)) begin
            next_r.os  = 6'd0;
            next_r.fsm = r.d_s2 ? SRX_IDLE : SRX_DATA;
          end
        end
      end
      SRX_DATA: begin
        // async bits are taken one full bit period apart, clocked bits
        // on each falling shift clock edge
        if (sync) begin
          sample = fall;
        end else if (tick) begin
          next_r.os = r.os + 6'd1;
          if (r.os == os_top) begin
            next_r.os = 6'd0;
            sample    = 1'b1;
          end
        end
        if (sample) begin
          next_r.shreg[r.bitcnt] = r.d_s2;
          next_r.bitcnt = r.bitcnt + 4'd1;
          if (r.bitcnt == nbits - 4'd1) begin
            next_r.bitcnt = 4'd0;
            if (sync) begin
              finish = 1'b1;
            end else begin
              next_r.fsm = SRX_STOP;
            end
          end
        end
      end
      SRX_STOP: begin
        if (tick) begin
          next_r.os = r.os + 6'd1;
          if (r.os == os_top) begin
            finish = 1'b1;
            ferr   = !r.d_s2;
          end
        end
      end
      default: next_r.fsm = SRX_IDLE;
    endcase

    // word complete: continue, or stop after a single word; the shift
    // register already holds every data bit, the stop level only decides
    // the framing error and must not overwrite the last data bit
    if (finish) begin
      nw.framing_error = ferr;
      nw.word          = next_r.shreg;
      // a narrow word never carries a ninth bit left from a wide one
      if (nbits == BITS_NARROW) begin
        nw.word[8] = 1'b0;
      end
      // a set overrun blocks every push; a full fifo with no pop in the
      // same cycle loses the new word and raises overrun
      if (r.overrun) begin
        push = 1'b0;
      end else if (r.count != FIFO_DEPTH || pop) begin
        push = 1'b1;
      end else begin
        next_r.overrun = 1'b1;
      end
      // single reception ends after one word; continuous enable wins when
      // both are set, so single enable then stays as written
      if (sync && !r.rs_ctl[RS_CONTINUOUS_RECEIVE-3]) begin
        next_r.rs_ctl[RS_SINGLE_RECEIVE-3] = 1'b0;
        next_r.fsm = SRX_IDLE;
      end else begin
        next_r.fsm = sync ? SRX_DATA : SRX_IDLE;
      end
    end

    // leaving the enabled state stops everything at once
    // a word cut short by this is dropped, never half pushed
    if (!active) begin
      next_r.fsm = SRX_IDLE;
    end

    // fifo bookkeeping; flag is count non-zero; a new word always goes to
    // the first free slot behind the old head, even when a pop and a push
    // fall in the same cycle, so the surviving word is never overwritten
    if (push) begin
      next_r.fifo[r.head ^ r.count[0]] = nw;
    end
    if (pop) begin
      next_r.head = !r.head;
    end
    next_r.count = r.count + {1'b0, push} - {1'b0, pop};
    next_r.irq   = (next_r.count != 2'd0) &&
                   r.periph_enables[PE_RECEIVE_IRQ_ENABLE];
  end

  // state register; synchronous reset loads constants only, and the data
  // synchroniser starts at the idle high level of the line
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      r                <= '0;
      r.fsm            <= SRX_IDLE;
      r.irq_control    <= RST_IRQ_CONTROL;
      r.periph_enables <= RST_ENABLES;
      r.tx_status      <= RST_TX_STATUS;
      r.baud           <= RST_BAUD;
      r.d_s1           <= 1'b1;
      r.d_s2           <= 1'b1;
      r.d_prev         <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from state
  // every output is a flop of the state struct, none is decoded
  assign apb_rsp_out       = r.rsp;
  assign serial_clk_out    = r.clk_out;
  assign serial_clk_oe_out = r.clk_oe;
  assign rx_irq_out        = r.irq;

endmodule // srx_serial_receiver
`default_nettype wire

// File: shared/srx_pkg.sv
// constants and carrier types of the serial receiver
package srx_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_CONTROL    = 8'h0b;
  localparam logic [7:0] IDX_PERIPH_FLAGS   = 8'h0c;
  localparam logic [7:0] IDX_RX_STATUS      = 8'h18;
  localparam logic [7:0] IDX_RX_DATA        = 8'h1a;
  localparam logic [7:0] IDX_PERIPH_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_TX_STATUS      = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIVISOR   = 8'h99;
  localparam int         APB_ADDR_W         = 10;
  // receive status and control bit positions
  localparam int RS_SERIAL_PORT_ENABLE = 7;
  localparam int RS_NINTH_BIT_ENABLE   = 6;
  localparam int RS_SINGLE_RECEIVE     = 5;
  localparam int RS_CONTINUOUS_RECEIVE = 4;
  localparam int RS_ADDRESS_DETECT     = 3;
  localparam int RS_FRAMING_ERROR      = 2;
  localparam int RS_OVERRUN_ERROR      = 1;
  localparam int RS_NINTH_BIT          = 0;
  // transmit status and control bit positions used here
  localparam int TS_CLOCK_SOURCE_MASTER = 7;
  localparam int TS_CLOCKED_MODE_SELECT = 4;
  localparam int TS_HIGH_SPEED_BAUD     = 2;
  localparam int TS_SHIFT_EMPTY         = 1;
  // flag and enable positions
  localparam int PF_RECEIVE_FLAG       = 5;
  localparam int PE_RECEIVE_IRQ_ENABLE = 5;
  // writable masks and reset values
  localparam logic [7:0] TX_STATUS_WMASK = 8'hf5;
  localparam logic [7:0] PE_WMASK        = 8'h7f;
  localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] RST_ENABLES     = 8'h00;
  localparam logic [7:0] RST_TX_STATUS   = 8'h00;
  localparam logic [7:0] RST_BAUD        = 8'h00;
  // word sizes, fifo depth and oversampling
  localparam logic [3:0] BITS_NARROW   = 4'd8;
  localparam logic [3:0] BITS_WIDE     = 4'd9;
  localparam logic [1:0] FIFO_DEPTH    = 2'd2;
  localparam logic [5:0] OVERSAMPLE_HI = 6'd15;  // 16 ticks per bit
  localparam logic [5:0] OVERSAMPLE_LO = 6'd63;  // 64 ticks per bit

  // receiver sequencing states
  typedef enum logic [3:0] {
    SRX_IDLE  = 4'b0001,
    SRX_START = 4'b0010,
    SRX_DATA  = 4'b0100,
    SRX_STOP  = 4'b1000
  } srx_state_e;

  // one received word as held in the fifo
  typedef struct packed {
    logic       framing_error;
    logic [8:0] word;
  } srx_word_s;

  // apb slave request
  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
  } srx_apb_req_s;

  // apb slave answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } srx_apb_rsp_s;
endpackage : srx_pkg

// File: tb/srx_checker.sv
// port assertions for the serial receiver
`timescale 1ns/1ns
`default_nettype none
module srx_checker
  import srx_pkg::*;
(
  // clock and reset
  input wire logic         mclk_in,
  input wire logic         reset_in,
  // apb and link outputs
  input wire srx_apb_req_s apb_req_in,
  input wire srx_apb_rsp_s apb_rsp_out,
  input wire logic         serial_clk_out,
  input wire logic         serial_clk_oe_out,
  input wire logic         rx_irq_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // setup cycle and answer shorthands
  wire logic setup = apb_req_in.psel & ~apb_req_in.penable;
  wire logic rdy   = apb_rsp_out.pready;

  property p_ready_next; setup |=> rdy; endproperty
  a_ready_next: assert property (p_ready_next) else $error("late pready");
  property p_ready_pulse; rdy |=> !rdy; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long pready");
  property p_ready_sel; !apb_req_in.psel |-> !rdy; endproperty
  a_ready_sel: assert property (p_ready_sel) else $error("stray pready");
  property p_hold; $changed(apb_rsp_out.prdata) |-> $past(setup); endproperty
  a_hold: assert property (p_hold) else $error("prdata moved");
  property p_upper; rdy |-> apb_rsp_out.prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_err_zero;
    rdy && apb_rsp_out.pslverr |-> apb_rsp_out.prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read data");
  property p_irq_fall; $fell(rx_irq_out) |-> $past(rdy) || $past(rdy, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
  property p_clk_idle; !serial_clk_oe_out |-> !serial_clk_out; endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clock idle");
endmodule // srx_checker
bind srx_serial_receiver srx_checker u_chk (
  .mclk_in(mclk_in), .reset_in(reset_in), .apb_req_in(apb_req_in),
  .apb_rsp_out(apb_rsp_out), .serial_clk_out(serial_clk_out),
  .serial_clk_oe_out(serial_clk_oe_out), .rx_irq_out(rx_irq_out));
`default_nettype wire

// File: tb/srx_link_model.sv
// far-side model: async transmitter and clocked slave
`timescale 1ns/1ns
`default_nettype none
module srx_link_model (
  // clocks from the bench and the receiver
  input  wire logic mclk_in,
  input  wire logic clk_in,
  input  wire logic clk_oe_in,
  // data line, driven high while idle
  output logic      data_out
);
  logic [8:0] sh = 9'h1ff;
  initial data_out = 1'b1;
  // async frame: start low, lsb first, stop high, 16 clocks a bit
  task automatic send(input logic [8:0] w, input int n);
    int i;
    @(posedge mclk_in);
    data_out <= 1'b0;
    repeat (16) @(posedge mclk_in);
    for (i = 0; i < n; i++) begin
      data_out <= w[i];
      repeat (16) @(posedge mclk_in);
    end
    data_out <= 1'b1;
    repeat (16) @(posedge mclk_in);
  endtask
  // word for the clocked slave
  task automatic load(input logic [8:0] w);
    sh = w;
  endtask
  // clocked slave: next bit on each rising shift clock edge
  always @(posedge clk_in) begin
    if (clk_oe_in) begin
      data_out <= sh[0];
      sh       <= {1'b1, sh[8:1]};
    end
  end
endmodule // srx_link_model
`default_nettype wire

// File: tb/test_serial_receiver.sv
// self-checking bench of the serial receiver
`timescale 1ns/1ns
`default_nettype none
module test_serial_receiver;
  import srx_pkg::*;
  logic         mclk_in  = 1'b0;
  logic         reset_in = 1'b1;
  srx_apb_req_s req      = '0;
  srx_apb_rsp_s rsp;
  wire logic    dpin, sclk, soe, irq;
  int           err_count = 0;
  int           cmp_count = 0;
  // clock
  always #5 mclk_in = ~mclk_in;
  // design and far side
  srx_serial_receiver dut (.mclk_in(mclk_in), .reset_in(reset_in),
    .apb_req_in(req), .apb_rsp_out(rsp), .serial_data_pin_in(dpin),
    .serial_clk_in(1'b0), .serial_clk_out(sclk),
    .serial_clk_oe_out(soe), .rx_irq_out(irq));
  srx_link_model link (.mclk_in(mclk_in), .clk_in(sclk),
    .clk_oe_in(soe), .data_out(dpin));
  // verdict
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge mclk_in);
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:{idx, 2'b00},
             pwdata:{24'h0, d}};
    @(posedge mclk_in);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("pready", 9'h1, 9'h0);
      close_out();
    end
    q = rsp.prdata[7:0];
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, idx, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] idx,
                    input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, idx, 8'h00, q);
    chk(nm, {1'b0, e}, {1'b0, q});
  endtask
  // bounded wait for the receive interrupt
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge mclk_in);
      n++;
    end
    chk("irq", 9'h1, {8'h0, irq});
    if (irq !== 1'b1) begin
      close_out();
    end
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'b0;
    rd("irq_control", IDX_IRQ_CONTROL, RST_IRQ_CONTROL);
    rd("flags", IDX_PERIPH_FLAGS, 8'h00);
    rd("rx_status", IDX_RX_STATUS, 8'h00);
    rd("rx_data", IDX_RX_DATA, 8'h00);
    rd("tx_status", IDX_TX_STATUS, 8'h02);
    rd("baud", IDX_BAUD_DIVISOR, RST_BAUD);
    rd("unmapped", 8'h00, 8'h00);
    chk("pslverr", 9'h1, {8'h0, rsp.pslverr});
    wr(IDX_PERIPH_ENABLES, 8'hff);
    rd("enables", IDX_PERIPH_ENABLES, PE_WMASK);
    wr(IDX_PERIPH_ENABLES, 8'h20);
    wr(IDX_IRQ_CONTROL, 8'hc0);
    rd("irq enables", IDX_IRQ_CONTROL, 8'hc0);
    $display("test registers done");
    wr(IDX_TX_STATUS, 8'h04);
    wr(IDX_RX_STATUS, 8'h90);
    link.send(9'h0a5, 8);
    wait_irq();
    rd("flag set", IDX_PERIPH_FLAGS, 8'h20);
    wr(IDX_PERIPH_FLAGS, 8'h00);
    rd("flag ro", IDX_PERIPH_FLAGS, 8'h20);
    rd("data", IDX_RX_DATA, 8'ha5);
    rd("flag clear", IDX_PERIPH_FLAGS, 8'h00);
    chk("irq low", 9'h0, {8'h0, irq});
    $display("test async word done");
    link.send(9'h011, 8);
    link.send(9'h022, 8);
    link.send(9'h033, 8);
    repeat (4) @(posedge mclk_in);
    rd("overrun", IDX_RX_STATUS, 8'h92);
    rd("first", IDX_RX_DATA, 8'h11);
    rd("second", IDX_RX_DATA, 8'h22);
    link.send(9'h044, 8);
    repeat (4) @(posedge mclk_in);
    rd("blocked", IDX_PERIPH_FLAGS, 8'h00);
    wr(IDX_RX_STATUS, 8'h80);
    rd("recover", IDX_RX_STATUS, 8'h80);
    wr(IDX_RX_STATUS, 8'h90);
    link.send(9'h055, 8);
    link.send(9'h066, 8);
    repeat (4) @(posedge mclk_in);
    rd("cont one", IDX_RX_DATA, 8'h55);
    rd("cont two", IDX_RX_DATA, 8'h66);
    $display("test overrun done");
    wr(IDX_RX_STATUS, 8'hd0);
    link.send(9'h1c3, 9);
    link.send(9'h0ff, 9);
    repeat (4) @(posedge mclk_in);
    rd("ninth set", IDX_RX_STATUS, 8'hd1);
    rd("wide one", IDX_RX_DATA, 8'hc3);
    rd("ninth next", IDX_RX_STATUS, 8'hd0);
    rd("wide two", IDX_RX_DATA, 8'hff);
    $display("test ninth bit done");
    wr(IDX_RX_STATUS, 8'h80);
    wr(IDX_BAUD_DIVISOR, 8'h07);
    wr(IDX_TX_STATUS, 8'h90);
    link.load(9'h13c);
    wr(IDX_RX_STATUS, 8'ha0);
    wait_irq();
    rd("clocked", IDX_RX_DATA, 8'h3c);
    rd("single off", IDX_RX_STATUS, 8'h80);
    link.load(9'h15a);
    wr(IDX_RX_STATUS, 8'hb0);
    wait_irq();
    rd("both data", IDX_RX_DATA, 8'h5a);
    rd("both kept", IDX_RX_STATUS, 8'hb0);
    wr(IDX_RX_STATUS, 8'h80);
    $display("test clocked done");
    close_out();
  end
endmodule // test_serial_receiver
`default_nettype wire
